// ---- design/ptws_pkg.sv ----
`default_nettype none
// shared constants for the period timer with scalers
package ptws_pkg;

  // register indexes; the bus byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_COUNT = 8'h11;
  localparam logic [7:0] IDX_CONTROL = 8'h12;
  localparam logic [7:0] IDX_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PERIOD = 8'h92;

  // decoded byte-address width and word-offset bits
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned WORD_LSB = 2;

  // control register field positions
  localparam int unsigned CTL_PRE_LO = 0;
  localparam int unsigned CTL_PRE_HI = 1;
  localparam int unsigned CTL_RUN = 2;
  localparam int unsigned CTL_POST_LO = 3;
  localparam int unsigned CTL_POST_HI = 6;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h7f;

  // interrupt flag and enable bit of the period event
  localparam int unsigned FLAG_PERIOD = 1;

  // reset values, and the value the count wraps to
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_ZERO = 8'h00;

  // prescaler terminal counts for the three ratios
  localparam logic [3:0] PRE_DIV1_LAST = 4'h0;
  localparam logic [3:0] PRE_DIV4_LAST = 4'h3;
  localparam logic [3:0] PRE_DIV16_LAST = 4'hf;
  localparam logic [1:0] PRE_SEL_DIV1 = 2'h0;
  localparam logic [1:0] PRE_SEL_DIV4 = 2'h1;

  // instruction clock is the device clock divided by this
  localparam int unsigned OSC_DIV = 4;

endpackage // ptws_pkg
`default_nettype wire

// ---- design/ptws_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module ptws_timer #(
  parameter int unsigned OSC_DIV = ptws_pkg::OSC_DIV
) (
  input wire logic hclk, // device clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, words only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready out
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  output logic period_match, // one-cycle match pulse
  output logic [7:0] timer_value, // running count
  output logic irq // level interrupt
);

  ////////////////////////////////////////////////////////////////////
  // elaboration checks

  localparam int unsigned DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

  // a divider of zero would never produce an instruction tick
  if (OSC_DIV < 1) begin : g_bad_div
    $error("OSC_DIV must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] count;
  logic [7:0] period;
  logic [7:0] control;
  logic period_flag;
  logic period_enable;

  // data phase bookkeeping
  logic dp_write;
  logic dp_read;
  logic [ptws_pkg::ADDR_W-1:0] dp_addr;

  // scaler state
  logic [DIV_W-1:0] osc_cnt;
  logic osc_tick;
  logic [3:0] pre_cnt;
  logic [3:0] post_cnt;

  ////////////////////////////////////////////////////////////////////
  // address decode

  localparam logic [ptws_pkg::ADDR_W-1:0] ADDR_FLAGS = {ptws_pkg::IDX_FLAGS, 2'b00};
  localparam logic [ptws_pkg::ADDR_W-1:0] ADDR_COUNT = {ptws_pkg::IDX_COUNT, 2'b00};
  localparam logic [ptws_pkg::ADDR_W-1:0] ADDR_CONTROL = {ptws_pkg::IDX_CONTROL, 2'b00};
  localparam logic [ptws_pkg::ADDR_W-1:0] ADDR_ENABLES = {ptws_pkg::IDX_ENABLES, 2'b00};
  localparam logic [ptws_pkg::ADDR_W-1:0] ADDR_PERIOD = {ptws_pkg::IDX_PERIOD, 2'b00};

  logic addr_phase;
  logic in_window;
  logic wr_count;
  logic wr_control;
  logic wr_period;
  logic wr_flags;
  logic wr_enables;
  logic [7:0] wdata;

  // a transfer is taken on nonseq or seq while the bus is ready
  assign addr_phase = hsel & htrans[1] & hready;

  // anything above the decoded window is unmapped
  assign in_window = (haddr[31:ptws_pkg::ADDR_W] == '0);

  // writes land at the end of their data phase
  assign wdata = hwdata[7:0];
  assign wr_count = dp_write & (dp_addr == ADDR_COUNT);
  assign wr_control = dp_write & (dp_addr == ADDR_CONTROL);
  assign wr_period = dp_write & (dp_addr == ADDR_PERIOD);
  assign wr_flags = dp_write & (dp_addr == ADDR_FLAGS);
  assign wr_enables = dp_write & (dp_addr == ADDR_ENABLES);

  ////////////////////////////////////////////////////////////////////
  // bus slave

  // capture the address phase; reads get one wait state so that a
  // write just before them is already visible when data is sampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= '0;
    end else if (addr_phase) begin
      dp_write <= hwrite & in_window;
      dp_read <= ~hwrite;
      dp_addr <= in_window ? haddr[ptws_pkg::ADDR_W-1:0] : '1;
    end else begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
    end
  end

  // ready drops for one cycle after a read is taken; the response is always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= ~(addr_phase & ~hwrite);
      hresp <= 1'b0;
    end
  end

  // read mux; unmapped and reserved bits read as zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (dp_addr)
      ADDR_FLAGS: rd_byte[ptws_pkg::FLAG_PERIOD] = period_flag;
      ADDR_ENABLES: rd_byte[ptws_pkg::FLAG_PERIOD] = period_enable;
      ADDR_COUNT: rd_byte = count;
      ADDR_CONTROL: rd_byte = control & ptws_pkg::CTL_WRITE_MASK;
      ADDR_PERIOD: rd_byte = period;
      default: rd_byte = 8'h00;
    endcase
  end

  logic rd_flags;
  assign rd_flags = dp_read & (dp_addr == ADDR_FLAGS);

  // read data is loaded during the wait state and held afterwards
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (dp_read) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software registers

  // period register, loaded only by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period <= ptws_pkg::PERIOD_RESET;
    end else if (wr_period) begin
      period <= wdata;
    end
  end

  // control register; bit 7 is not stored at all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control <= ptws_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      control <= wdata & ptws_pkg::CTL_WRITE_MASK;
    end
  end

  // enable bit of the period interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_enable <= 1'b0;
    end else if (wr_enables) begin
      period_enable <= wdata[ptws_pkg::FLAG_PERIOD];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control fields

  logic run_enable;
  logic [1:0] prescale_select;
  logic [3:0] postscale_select;
  logic [3:0] pre_last;

  assign run_enable = control[ptws_pkg::CTL_RUN];
  assign prescale_select = control[ptws_pkg::CTL_PRE_HI:ptws_pkg::CTL_PRE_LO];
  assign postscale_select =
    control[ptws_pkg::CTL_POST_HI:ptws_pkg::CTL_POST_LO];

  // the upper select bit alone chooses divide by sixteen
  always_comb begin
    case (prescale_select)
      ptws_pkg::PRE_SEL_DIV1: pre_last = ptws_pkg::PRE_DIV1_LAST;
      ptws_pkg::PRE_SEL_DIV4: pre_last = ptws_pkg::PRE_DIV4_LAST;
      default: pre_last = ptws_pkg::PRE_DIV16_LAST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // instruction clock divider

  // free-running so the instruction rate does not depend on software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt <= '0;
      osc_tick <= 1'b0;
    end else begin
      osc_cnt <= (osc_cnt == DIV_LAST) ? '0 : osc_cnt + DIV_W'(1);
      osc_tick <= (osc_cnt == DIV_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // prescaler

  logic scaler_clear;
  logic timer_tick;
  logic match_evt;

  // either register write restarts both scalers from zero
  assign scaler_clear = wr_count | wr_control;

  // a stopped timer does not even advance the prescaler, saving power
  assign timer_tick = osc_tick & run_enable & (pre_cnt == pre_last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt <= 4'h0;
    end else if (scaler_clear) begin
      pre_cnt <= 4'h0;
    end else if (osc_tick && run_enable) begin
      if (pre_cnt == pre_last) begin
        pre_cnt <= 4'h0;
      end else begin
        pre_cnt <= pre_cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter

  // a software write to the count wins over a tick in the same cycle
  assign match_evt = timer_tick & ~wr_count & (count == period);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= ptws_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count <= wdata;
    end else if (timer_tick) begin
      if (count == period) begin
        count <= ptws_pkg::COUNT_ZERO;
      end else begin
        count <= count + 8'h01;
      end
    end
  end
  // a control write reaches none of the branches above

  ////////////////////////////////////////////////////////////////////
  // time base outputs

  // the match pulse is taken before the postscaler; the count copy for
  // the pwm comparators runs one cycle behind the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_match <= 1'b0;
      timer_value <= ptws_pkg::COUNT_RESET;
    end else begin
      period_match <= match_evt;
      timer_value <= count;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // postscaler and interrupt

  logic post_done;
  assign post_done = match_evt & (post_cnt == postscale_select);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_cnt <= 4'h0;
    end else if (scaler_clear) begin
      post_cnt <= 4'h0;
    end else if (match_evt) begin
      if (post_done) begin
        post_cnt <= 4'h0;
      end else begin
        post_cnt <= post_cnt + 4'h1;
      end
    end
  end

  // sticky flag: read clears it, a write stores it, a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_flag <= 1'b0;
    end else if (post_done) begin
      period_flag <= 1'b1;
    end else if (wr_flags) begin
      period_flag <= wdata[ptws_pkg::FLAG_PERIOD];
    end else if (rd_flags) begin
      period_flag <= 1'b0;
    end
  end

  // registered, so the line follows the flag by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= period_flag & period_enable;
    end
  end

  // size is unused: only whole-word transfers are supported
  logic unused_size;
  assign unused_size = ^hsize;

endmodule // ptws_timer
`default_nettype wire

// ---- bench/ptws_timer_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ptws_timer_checker #(
  parameter int unsigned OSC_DIV = 4
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic hreadyout, // ready out
  input wire logic [31:0] hrdata, // read data
  input wire logic period_match, // match pulse
  input wire logic [7:0] timer_value, // count copy
  input wire logic irq // interrupt
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic [3:0] cnt_hist;
  logic [3:0] any_hist;
  assign take = hsel && htrans[1] && hready;
  // write history; a write may legally move the count or the irq
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_hist <= 4'h0;
      any_hist <= 4'h0;
    end else begin
      cnt_hist <= {cnt_hist[2:0], take && hwrite && haddr == 32'h44};
      any_hist <= {any_hist[2:0], take && hwrite};
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence rd_take;
    take && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  read_wait_a: assert property (rd_take |=> one_wait)
    else $error("read wait state wrong");
  write_ready_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  ctl_bit7_a: assert property (take && !hwrite && haddr == 32'h48 |-> ##2 !hrdata[7])
    else $error("control bit 7 not zero");
  match_zero_a: assert property (period_match |=> timer_value == 8'h00)
    else $error("no wrap on match");
  match_pulse_a: assert property (period_match |=> !period_match)
    else $error("match pulse too long");
  timer_step_a: assert property ($changed(timer_value) && cnt_hist == 4'h0 |->
    timer_value == $past(timer_value) + 8'h01 || timer_value == 8'h00)
    else $error("count jumped");
  tick_spacing_a: assert property ($changed(timer_value) && cnt_hist == 4'h0 |=>
    ($stable(timer_value) || cnt_hist != 4'h0) [*3])
    else $error("count faster than osc tick");
  irq_cause_a: assert property ($rose(irq) |-> $past(period_match) || any_hist != 4'h0)
    else $error("irq without event");
endmodule // ptws_timer_checker

bind ptws_timer ptws_timer_checker #(.OSC_DIV(OSC_DIV)) i_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .period_match(period_match),
  .timer_value(timer_value), .irq(irq));
`default_nettype wire

// ---- bench/ptws_timer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ptws_timer_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_wait = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, period_match, irq;
  logic [31:0] hrdata;
  logic [7:0] timer_value, p, r, got;
  logic [7:0] q[$];
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  int posts[3] = '{0, 1, 15};

  // free-running bus clock
  always #5 hclk = ~hclk;

  ptws_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .period_match(period_match),
    .timer_value(timer_value), .irq(irq));

  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // single word transfer; entered and left just after a rising edge
  task xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    rd_wait <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_wait <= 1'b0;
  endtask

  task wr(input logic [31:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rd(input logic [31:0] a, input logic [7:0] e);
    q.push_back(e);
    xfer(a, 1'b0, 8'h00);
  endtask

  // cycles between two consecutive match pulses
  task gap(input int exp);
    n = 0;
    do @(posedge hclk); while (period_match !== 1'b1);
    do begin
      @(posedge hclk);
      n++;
    end while (period_match !== 1'b1 && n < 2000);
    chk(n, exp, "match gap");
  endtask

  // read data compared against the oldest note; timeout guards any hang
  always @(posedge hclk) begin
    cyc++;
    if (rd_wait === 1'b1 && hreadyout === 1'b1) begin
      got = q.pop_front();
      chk(hrdata, {24'h0, got}, "rdata");
      chk({31'h0, hresp}, 32'h0, "hresp");
    end
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8301));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h44, 8'h00);
    rd(32'h248, 8'hff);
    rd(32'h48, 8'h00);
    rd(32'h30, 8'h00);
    rd(32'h230, 8'h00);
    rd(32'h400, 8'h00);
    wr(32'h48, 8'hff);
    rd(32'h48, 8'h7f);
    p = 8'($urandom_range(1, 4));
    wr(32'h248, p);
    rd(32'h248, p);
    wr(32'h44, 8'h00);
    // every prescale code, post 1:1, running
    for (int ps = 0; ps < 4; ps++) begin
      wr(32'h48, {6'h01, 2'(ps)});
      gap((p + 1) * (ps == 0 ? 1 : ps == 1 ? 4 : 16) * ptws_pkg::OSC_DIV);
    end
    // stopped counter holds a written value across a control write
    r = 8'($urandom_range(0, 255));
    wr(32'h48, 8'h00);
    wr(32'h44, r);
    repeat (100) @(posedge hclk);
    rd(32'h44, r);
    wr(32'h48, 8'h78);
    rd(32'h44, r);
    rd(32'h48, 8'h78);
    // postscaler boundaries, period 1, irq enabled
    wr(32'h248, 8'h01);
    wr(32'h230, 8'h02);
    foreach (posts[i]) begin
      wr(32'h48, 8'h00);
      wr(32'h30, 8'h00);
      wr(32'h44, 8'h00);
      wr(32'h48, {1'b0, 4'(posts[i]), 3'b100});
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
        @(posedge hclk);
        if (period_match === 1'b1)
          n++;
      end
      chk(n, posts[i] + 1, "post count");
      rd(32'h30, 8'h02);
    end
    // masked: flag still latches but irq stays low
    wr(32'h230, 8'h00);
    wr(32'h30, 8'h00);
    // long enough for a full sixteen-match postscale run, so the flag is set again
    repeat (160) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rd(32'h30, 8'h02);
    summarize();
  end
endmodule // ptws_timer_tb
`default_nettype wire
